// ===== logic/panel_scan.sv
// scan driver logic: gate line walker and six-dot column sampler
// Overview of operation
// - select each of 484 gate lines in turn, one per horizontal period
// - double-speed tv mode selects gate lines two at a time
// - sample every column group of the selected line each horizontal period
// - a pixel is written only where line and column select coincide
// - direction inputs pick right/left and down/up scan
// - all six video inputs sampled at once, six adjacent dots per step
`timescale 1ns/1ns
`include "panel_scan_params.svh"
module panel_scan
   import panel_scan_pkg::*;
(
   // clock and reset
   input  wire logic                         MCLK,
   input  wire logic                         RST_B,
   // timing from the controller
   input  wire logic                         VERT_START_PULSE,
   input  wire logic                         VERT_SHIFT_CLK,
   input  wire logic                         HORIZ_START_PULSE,
   input  wire logic                         HORIZ_SHIFT_CLK_A,
   input  wire logic                         HORIZ_SHIFT_CLK_B,
   // mode controls
   input  wire logic                         HORIZ_DIR_SEL,
   input  wire logic                         VERT_DIR_SEL,
   input  wire logic                         PAIR_MODE,
   input  wire logic                         SHADING_CLEAR,
   // sampled video
   input  wire logic [`VIDEO_CH*`VIDEO_W-1:0] VIDEO_IN,
   input  wire logic [`VIDEO_W-1:0]          UNIFORMITY_VIDEO,
   // pixel write stream
   output pixel_write_type                   PIX_WRITE,
   output logic                              PIX_VALID,
   input  wire logic                         PIX_READY,
   // scan state
   output logic [`GATE_IDX_W-1:0]            GATE_LINE,
   output logic                              GATE_PAIRED,
   output logic                              GATE_ACTIVE,
   output logic                              SHADING_ACTIVE,
   output logic                              SAMPLE_STALL
);
   // two-stage synchronisers for all pin inputs except RST_B and PIX_READY
   localparam int NS = 9;
   logic [NS-1:0]                 pin_in, s1_r, s2_r, s3_r;
   logic [`VIDEO_CH*`VIDEO_W-1:0] vid1_r, vid2_r;
   logic [`VIDEO_W-1:0]           uni1_r, uni2_r;
   assign pin_in = {VERT_START_PULSE, VERT_SHIFT_CLK, HORIZ_START_PULSE,
                    HORIZ_SHIFT_CLK_A, HORIZ_SHIFT_CLK_B, HORIZ_DIR_SEL,
                    VERT_DIR_SEL, PAIR_MODE, SHADING_CLEAR};
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         vid1_r <= '0;
         vid2_r <= '0;
         uni1_r <= '0;
         uni2_r <= '0;
      end
      else
      begin
         s1_r   <= pin_in;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         vid1_r <= VIDEO_IN;
         vid2_r <= vid1_r;
         uni1_r <= UNIFORMITY_VIDEO;
         uni2_r <= uni1_r;
      end
   end
   logic start_v, vclk_rise, start_h, hclk_a_rise, hclk_b_rise;
   logic right_scan, down_scan, pair, clear_lvl;
   // vertical start is active low in up scan
   assign start_v     = down_scan ? s2_r[8] : !s2_r[8];
   assign vclk_rise   = s2_r[7] && !s3_r[7];
   assign start_h     = s2_r[6];
   assign hclk_a_rise = s2_r[5] && !s3_r[5];
   assign hclk_b_rise = s2_r[4] && !s3_r[4];
   assign right_scan  = s2_r[3];
   assign down_scan   = s2_r[2];
   assign pair        = s2_r[1];
   assign clear_lvl   = s2_r[0];

   // vertical walker
   vstate_type             vstate_r, vstate_nxt;
   logic [`GATE_IDX_W-1:0] line_r, line_nxt;
   logic                   paired_r, paired_nxt;
   always_comb
   begin
      vstate_nxt = vstate_r;
      line_nxt   = line_r;
      paired_nxt = paired_r;
      case (vstate_r)
         V_IDLE:
         begin
            if (start_v && vclk_rise)
            begin
               vstate_nxt = V_SCAN;
               paired_nxt = pair;
               line_nxt   = down_scan ? `GATE_ZERO : `GATE_LAST;
            end
         end
         V_SCAN:
         begin
            if (vclk_rise)
            begin
               if (start_v)
               begin
                  paired_nxt = pair;
                  line_nxt   = down_scan ? `GATE_ZERO : `GATE_LAST;
               end
               else if (down_scan)
               begin
                  if (line_r >= (paired_r ? `GATE_PAIR_LAST : `GATE_LAST))
                     vstate_nxt = V_IDLE;
                  else
                     line_nxt = paired_r ? `GATE_IDX_W'(line_r + 2'd2)
                                         : `GATE_IDX_W'(line_r + 1'b1);
               end
               else
               begin
                  if (line_r <= (paired_r ? `GATE_PAIR_FIRST : `GATE_ZERO))
                     vstate_nxt = V_IDLE;
                  else
                     line_nxt = paired_r ? `GATE_IDX_W'(line_r - 2'd2)
                                         : `GATE_IDX_W'(line_r - 1'b1);
               end
            end
         end
         default: vstate_nxt = V_IDLE;
      endcase
   end

   // horizontal sampler: one token, six dots per step
   logic                   hrun_r, hrun_nxt;
   logic [`STEP_IDX_W-1:0] step_r, step_nxt;
   logic                   hphase_r, hphase_nxt;
   logic                   fire;
   pixel_write_type        wr;
   logic                   fifo_ready;
   always_comb
   begin
      hrun_nxt   = hrun_r;
      step_nxt   = step_r;
      hphase_nxt = hphase_r;
      fire       = 1'b0;
      if (start_h && hclk_a_rise)
      begin
         hrun_nxt   = 1'b1;
         hphase_nxt = 1'b1;
         step_nxt   = right_scan ? `STEP_ZERO : `STEP_LAST;
      end
      else if (hrun_r && (hphase_r ? hclk_b_rise : hclk_a_rise))
      begin
         hphase_nxt = !hphase_r;
         fire       = (vstate_r == V_SCAN);
         if (step_r == (right_scan ? `STEP_LAST : `STEP_ZERO))
            hrun_nxt = 1'b0;
         else
            step_nxt = right_scan ? `STEP_IDX_W'(step_r + 1'b1)
                                  : `STEP_IDX_W'(step_r - 1'b1);
      end
   end
   // all six channels taken from one synchronised sample
   assign wr = {step_r, line_r, vid2_r, uni2_r};

   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         vstate_r <= V_IDLE;
         line_r   <= `GATE_ZERO;
         paired_r <= 1'b0;
         hrun_r   <= 1'b0;
         step_r   <= `STEP_ZERO;
         hphase_r <= 1'b0;
      end
      else
      begin
         vstate_r <= vstate_nxt;
         line_r   <= line_nxt;
         paired_r <= paired_nxt;
         hrun_r   <= hrun_nxt;
         step_r   <= step_nxt;
         hphase_r <= hphase_nxt;
      end
   end

   // registered fifo output stage
   pixel_write_type fo_data;
   logic            fo_valid, fo_take;
   pixel_write_type pw_r, pw_nxt;
   logic            pv_r, pv_nxt;
   logic            stall_r, stall_nxt;
   sample_fifo #(.WIDTH($bits(pixel_write_type)), .DEPTH(`FIFO_DEPTH)) fifo
   (
      .clk       (MCLK),
      .rst_b     (RST_B),
      .in_data   (wr),
      .in_valid  (fire),
      .in_ready  (fifo_ready),
      .out_data  (fo_data),
      .out_valid (fo_valid),
      .out_ready (fo_take)
   );
   assign fo_take = !pv_r || PIX_READY;
   always_comb
   begin
      pw_nxt    = pw_r;
      pv_nxt    = pv_r;
      stall_nxt = stall_r || (fire && !fifo_ready);
      if (fo_take)
      begin
         pv_nxt = fo_valid;
         if (fo_valid)
            pw_nxt = fo_data;
      end
   end
   always_ff @(posedge MCLK)
   begin
      if (!RST_B)
      begin
         pw_r           <= '0;
         pv_r           <= 1'b0;
         stall_r        <= 1'b0;
         GATE_LINE      <= `GATE_ZERO;
         GATE_PAIRED    <= 1'b0;
         GATE_ACTIVE    <= 1'b0;
         SHADING_ACTIVE <= 1'b0;
      end
      else
      begin
         pw_r           <= pw_nxt;
         pv_r           <= pv_nxt;
         stall_r        <= stall_nxt;
         GATE_LINE      <= line_r;
         GATE_PAIRED    <= paired_r;
         GATE_ACTIVE    <= (vstate_r == V_SCAN);
         SHADING_ACTIVE <= clear_lvl;
      end
   end
   assign PIX_WRITE    = pw_r;
   assign PIX_VALID    = pv_r;
   assign SAMPLE_STALL = stall_r;

   gate_step_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      (vstate_r == V_SCAN && vclk_rise && !start_v && down_scan && !paired_r
       && line_r < `GATE_LAST) |=> line_r == $past(line_r) + 1'b1)
      else $error("gate line did not advance by one");
   pair_step_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      (vstate_r == V_SCAN && vclk_rise && !start_v && down_scan && paired_r
       && line_r < `GATE_PAIR_LAST) |=> line_r == $past(line_r) + 2'd2)
      else $error("paired gate line did not advance by two");
   col_fire_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      fire |-> hrun_r && vstate_r == V_SCAN)
      else $error("column sampled outside a selected line");
   dir_load_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      (start_h && hclk_a_rise && !right_scan) |=> step_r == `STEP_LAST)
      else $error("left scan did not start at last column");
   // start events seen after synchronisation
   sequence down_start_s;
      start_v && vclk_rise && down_scan;
   endsequence
   sequence up_start_s;
      start_v && vclk_rise && !down_scan;
   endsequence
   start_load_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      down_start_s |=> vstate_r == V_SCAN && line_r == `GATE_ZERO)
      else $error("vertical start did not load first line");
   up_load_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      up_start_s |=> vstate_r == V_SCAN && line_r == `GATE_LAST)
      else $error("up scan start did not load last line");
   six_dot_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      fire |-> wr.video.dots == $past(VIDEO_IN, 2))
      else $error("six dots not sampled together");
   col_end_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      (hrun_r && fire && right_scan && step_r == `STEP_LAST) |=> !hrun_r)
      else $error("horizontal scan ran past last column");
endmodule

// ===== logic/panel_scan_params.svh
// constants for the panel scan driver logic
`ifndef PANEL_SCAN_PARAMS_SVH
`define PANEL_SCAN_PARAMS_SVH
`define GATE_LINES     484
`define GATE_IDX_W     9
`define SIG_COLUMNS    644
`define SAMPLE_STEPS   108
`define STEP_IDX_W     7
`define VIDEO_CH       6
`define VIDEO_W        8
`define FIFO_DEPTH     8
`define GATE_LAST      9'h1e3
`define GATE_PAIR_LAST 9'h1e2
`define GATE_PAIR_FIRST 9'h001
`define STEP_LAST      7'h6b
`define GATE_ZERO      9'h000
`define STEP_ZERO      7'h00
`endif

// ===== logic/panel_scan_pkg.sv
// types for the panel scan driver logic
`include "panel_scan_params.svh"
package panel_scan_pkg;
   typedef struct packed {
      logic [`VIDEO_CH*`VIDEO_W-1:0] dots;
      logic [`VIDEO_W-1:0]           uniformity;
   } video_word_type;
   typedef struct packed {
      logic [`STEP_IDX_W-1:0]        step;
      logic [`GATE_IDX_W-1:0]        line;
      video_word_type                video;
   } pixel_write_type;
   typedef enum logic [1:0] {V_IDLE, V_SCAN} vstate_type;
endpackage

// ===== logic/sample_fifo.sv
// small flip-flop fifo for sampled video words
`timescale 1ns/1ns
module sample_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;
   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_comb
   begin
      wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r;
      if (push && !pop)
         cnt_nxt = (AW+1)'(cnt_r + 1'b1);
      else if (pop && !push)
         cnt_nxt = (AW+1)'(cnt_r - 1'b1);
   end
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : slot
         always_ff @(posedge clk)
         begin
            if (push && wp_r == g[AW-1:0])
               mem_r[g] <= in_data;
         end
      end
   endgenerate
endmodule

// ===== sim/scan_timing_gen.sv
// timing generator model driving the panel scan pins
`timescale 1ns/1ns
`include "panel_scan_params.svh"
module scan_timing_gen
(
   // vertical timing
   output logic                          vert_start_pulse,
   output logic                          vert_shift_clk,
   // horizontal timing
   output logic                          horiz_start_pulse,
   output logic                          horiz_shift_clk_a,
   output logic                          horiz_shift_clk_b,
   // video and control
   output logic [`VIDEO_CH*`VIDEO_W-1:0] video_in,
   output logic [`VIDEO_W-1:0]           uniformity_video,
   output logic                          shading_clear
);
   logic pol_r;
   logic vck_inv_r;
   initial
   begin
      vert_start_pulse = 1'b0;
      vert_shift_clk = 1'b0;
      horiz_start_pulse = 1'b0;
      horiz_shift_clk_a = 1'b0;
      horiz_shift_clk_b = 1'b0;
      video_in = '0;
      uniformity_video = '0;
      shading_clear = 1'b0;
      pol_r = 1'b0;
      vck_inv_r = 1'b0;
   end
   // one 125 ns period; clocks rest low between pulses
   task automatic tick(ref logic c);
      #3 c = 1'b1;
      #63 c = 1'b0;
      #59;
   endtask
   // inverted phase rests high and rises late in the period
   task automatic vtick();
      #3 vert_shift_clk = ~vck_inv_r;
      #63 vert_shift_clk = vck_inv_r;
      #59;
   endtask
   task automatic set_vck_phase(input logic inv);
      vck_inv_r = inv;
      vert_shift_clk = inv;
   endtask
   // start pulse active low in up scan
   task automatic frame_start(input logic dn);
      vert_start_pulse = dn;
      vtick();
      vert_start_pulse = !dn;
   endtask
   task automatic line_step();
      vtick();
   endtask
   task automatic row_start();
      pol_r = ~pol_r;
      horiz_start_pulse = 1'b1;
      tick(horiz_shift_clk_a);
      horiz_start_pulse = 1'b0;
   endtask
   // channels settle one by one, all before the shift clock edge
   task automatic dot_step(input int s, input logic [`VIDEO_CH*`VIDEO_W-1:0] d,
                           input logic [`VIDEO_W-1:0] u, input logic rt);
      logic [`VIDEO_CH*`VIDEO_W-1:0] x;
      int                            ch;
      x = d ^ {(`VIDEO_CH*`VIDEO_W){pol_r}};
      uniformity_video = u;
      for (int k = 0; k < `VIDEO_CH; k++)
      begin
         ch = rt ? k : `VIDEO_CH - 1 - k;
         video_in[ch*`VIDEO_W +: `VIDEO_W] = x[ch*`VIDEO_W +: `VIDEO_W];
         #1;
      end
      if (s % 2 == 0)
         horiz_shift_clk_b = 1'b1;
      else
         horiz_shift_clk_a = 1'b1;
      #63;
      horiz_shift_clk_a = 1'b0;
      horiz_shift_clk_b = 1'b0;
      #56;
   endtask
   task automatic set_clear(input logic v);
      shading_clear = v;
   endtask
endmodule

// ===== sim/lcd_panel_scan_drivers_tb.sv
// self-checking bench for the panel scan driver logic
`timescale 1ns/1ns
`include "panel_scan_params.svh"
module lcd_panel_scan_drivers_tb
   import panel_scan_pkg::*;
;
   localparam int DW = `VIDEO_CH*`VIDEO_W;
   localparam int PW = $bits(pixel_write_type);
   logic MCLK = 1'b0;
   logic RST_B = 1'b0;
   logic horiz_dir_sel = 1'b1;
   logic vert_dir_sel = 1'b1;
   logic pair_mode = 1'b0;
   logic pix_ready = 1'b0;
   logic hold = 1'b0;
   logic quiet = 1'b0;
   logic pol = 1'b0;
   logic vert_start_pulse, vert_shift_clk, horiz_start_pulse;
   logic horiz_shift_clk_a, horiz_shift_clk_b, shading_clear;
   logic [DW-1:0] video_in;
   logic [`VIDEO_W-1:0] uniformity_video;
   logic [`GATE_IDX_W-1:0] gate_line;
   logic pix_valid, gate_paired, gate_active, shading_active, sample_stall;
   pixel_write_type pix_write;
   pixel_write_type exp_q[$];
   int num_errors = 0;
   int num_checks = 0;
   always #5 MCLK = ~MCLK;
   scan_timing_gen gen_inst (.vert_start_pulse(vert_start_pulse),
      .vert_shift_clk(vert_shift_clk), .horiz_start_pulse(horiz_start_pulse),
      .horiz_shift_clk_a(horiz_shift_clk_a),
      .horiz_shift_clk_b(horiz_shift_clk_b), .video_in(video_in),
      .uniformity_video(uniformity_video), .shading_clear(shading_clear));
   panel_scan panel_scan_inst (.MCLK(MCLK), .RST_B(RST_B),
      .VERT_START_PULSE(vert_start_pulse), .VERT_SHIFT_CLK(vert_shift_clk),
      .HORIZ_START_PULSE(horiz_start_pulse),
      .HORIZ_SHIFT_CLK_A(horiz_shift_clk_a),
      .HORIZ_SHIFT_CLK_B(horiz_shift_clk_b), .HORIZ_DIR_SEL(horiz_dir_sel),
      .VERT_DIR_SEL(vert_dir_sel), .PAIR_MODE(pair_mode),
      .SHADING_CLEAR(shading_clear), .VIDEO_IN(video_in),
      .UNIFORMITY_VIDEO(uniformity_video), .PIX_WRITE(pix_write),
      .PIX_VALID(pix_valid), .PIX_READY(pix_ready), .GATE_LINE(gate_line),
      .GATE_PAIRED(gate_paired), .GATE_ACTIVE(gate_active),
      .SHADING_ACTIVE(shading_active), .SAMPLE_STALL(sample_stall));
   task automatic check(input string n, input logic [PW-1:0] s,
                        input logic [PW-1:0] e);
      num_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge MCLK)
      #1 pix_ready = hold ? 1'b0 : 1'($urandom);
   // each accepted write is matched against the oldest note
   always @(posedge MCLK)
      if (RST_B && pix_ready && pix_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("stray write", 1, 0);
         else
            check("pixel", pix_write, exp_q.pop_front());
      end
   task automatic drain();
      int n = 0;
      while (exp_q.size() > 0 && n < 400)
      begin
         @(posedge MCLK);
         n++;
      end
      if (exp_q.size() > 0)
      begin
         check("drain", 1, 0);
         test_done();
      end
   endtask
   task automatic row(input logic [`GATE_IDX_W-1:0] ln);
      pixel_write_type e;
      logic [DW-1:0] d;
      pol = ~pol;
      gen_inst.row_start();
      for (int s = 0; s < `SAMPLE_STEPS; s++)
      begin
         d = DW'({$urandom, $urandom});
         e.step = horiz_dir_sel ? s[6:0] : 7'(`STEP_LAST - s);
         e.line = ln;
         e.video.uniformity = 8'($urandom);
         e.video.dots = d ^ {DW{pol}};
         if (!quiet)
            exp_q.push_back(e);
         gen_inst.dot_step(s, d, e.video.uniformity,
                           horiz_dir_sel);
      end
      drain();
   endtask
   task automatic frame(input logic dn, input logic pm, input logic rt);
      logic [`GATE_IDX_W-1:0] ln;
      int last;
      @(posedge MCLK);
      #1 vert_dir_sel = dn;
      pair_mode = pm;
      last = pm ? 241 : 483;
      ln = dn ? `GATE_ZERO : `GATE_LAST;
      gen_inst.frame_start(dn);
      for (int i = 0; i <= last; i++)
      begin
         if (i > 0)
            gen_inst.line_step();
         if (i > 0)
            ln = dn ? ln + (pm ? 2 : 1) : ln - (pm ? 2 : 1);
         repeat (6) @(posedge MCLK);
         check("line", gate_line, ln);
         check("paired", gate_paired, pm);
         check("active", gate_active, 1);
         #1 horiz_dir_sel = rt ^ i[0];
         if (i < 2 || i == last)
            row(ln);
      end
      gen_inst.line_step();
      repeat (6) @(posedge MCLK);
      check("active", gate_active, 0);
   endtask
   initial
   begin
      void'($urandom(15));
      repeat (5) @(posedge MCLK);
      check("reset", {gate_line, gate_active, pix_valid, sample_stall}, 0);
      #1 RST_B = 1'b1;
      quiet = 1'b1;
      row(`GATE_ZERO);
      repeat (20) @(posedge MCLK);
      quiet = 1'b0;
      gen_inst.set_clear(1'b1);
      repeat (6) @(posedge MCLK);
      check("shading", shading_active, 1);
      gen_inst.set_clear(1'b0);
      repeat (6) @(posedge MCLK);
      check("shading", shading_active, 0);
      frame(1'b1, 1'b0, 1'b1);
      frame(1'b0, 1'b0, 1'b0);
      frame(1'b1, 1'b1, 1'b1);
      gen_inst.set_vck_phase(1'b1);
      frame(1'b0, 1'b1, 1'b0);
      quiet = 1'b1;
      hold = 1'b1;
      gen_inst.frame_start(vert_dir_sel);
      row(`GATE_ZERO);
      repeat (6) @(posedge MCLK);
      check("stall", sample_stall, 1);
      #1 RST_B = 1'b0;
      repeat (3) @(posedge MCLK);
      check("reset", {gate_line, gate_active, pix_valid, sample_stall}, 0);
      test_done();
   end
endmodule
